// ==== hdl/trip_vote.sv ====
// trip voting, manual trip, trouble and nuclear range permissives
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "trip_vote_consts.svh"
module trip_vote
  import trip_vote_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic [15:0] i_sg_lowlow,
  input  wire logic [2:0]  i_etf_contact_n,
  input  wire logic [3:0]  i_stop_vlv_contact_n,
  input  wire logic        i_trip_pwr_ok,
  input  wire logic        i_si_actuate,
  input  wire logic [1:0]  i_man_trip,
  input  wire logic [17:0] i_trouble,
  input  wire logic [1:0]  i_ir_above,
  input  wire logic [3:0]  i_pr_above_p10,
  input  wire logic [3:0]  i_pr_above_p9,
  input  wire logic [1:0]  i_sr_block_sw,
  input  wire logic [1:0]  i_sr_reset_sw,
  input  wire logic [3:0]  i_range_block_sw,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [1:0]       o_uv_coil,
  output logic [1:0]       o_shunt_coil,
  output logic [1:0]       o_train_alarm,
  output logic             o_reactor_trip,
  output logic             o_p6,
  output logic             o_p10,
  output logic             o_sr_hv_on,
  output logic             o_sr_trip_active,
  output logic [1:0]       o_ir_trip_active,
  output logic [1:0]       o_prl_trip_active
);
  localparam int NIN = 45;
  // count of set bits, used by the level, fluid, p9 and p10 votes
  function automatic logic [4:0] ones(input logic [17:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int k = 0; k < 18; k++) begin
      n = n + {4'h0, v[k]};
    end
    return n;
  endfunction
  // two-stage synchroniser on every field input
  logic [NIN-1:0] meta_q;
  logic [NIN-1:0] sync_q;
  logic [NIN-1:0] raw;
  assign raw = {i_sg_lowlow, i_etf_contact_n, i_stop_vlv_contact_n,
                i_trip_pwr_ok, i_si_actuate, i_man_trip, i_ir_above,
                i_pr_above_p10, i_pr_above_p9, i_sr_block_sw,
                i_sr_reset_sw, i_range_block_sw};
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end
  logic [15:0] sg_s;
  logic [2:0]  etf_n_s;
  logic [3:0]  vlv_n_s;
  logic        pwr_ok_s;
  logic        si_s;
  logic [1:0]  man_s;
  logic [1:0]  ir_s;
  logic [3:0]  p10_s;
  logic [3:0]  p9_s;
  logic [1:0]  srblk_s;
  logic [1:0]  srrst_s;
  logic [3:0]  rblk_s;
  assign {sg_s, etf_n_s, vlv_n_s, pwr_ok_s, si_s, man_s, ir_s, p10_s,
          p9_s, srblk_s, srrst_s, rblk_s} = sync_q;

  // trouble inputs are synchronised separately, 9 per train
  logic [17:0] tr_meta_q;
  logic [17:0] tr_q;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tr_meta_q <= '0;
      tr_q      <= '0;
    end else begin
      tr_meta_q <= i_trouble;
      tr_q      <= tr_meta_q;
    end
  end

  // lag filter: a level bit must hold steadily before it votes
  logic [15:0]           sg_f_q;
  logic [`TV_LAG_W-1:0]  lag_cnt_q [16];
  localparam logic [`TV_LAG_W-1:0] LAG_MAX = `TV_LAG_W'(`TV_LAG_CYC);
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sg_f_q <= '0;
      for (int k = 0; k < 16; k++) begin
        lag_cnt_q[k] <= '0;
      end
    end else begin
      for (int k = 0; k < 16; k++) begin
        if (sg_s[k] == sg_f_q[k]) begin
          lag_cnt_q[k] <= '0;
        end else if (lag_cnt_q[k] >= LAG_MAX - 1'b1) begin
          sg_f_q[k]    <= sg_s[k];
          lag_cnt_q[k] <= '0;
        end else begin
          lag_cnt_q[k] <= lag_cnt_q[k] + 1'b1;
        end
      end
    end
  end
  // software controls: bit0 forces a trip test
  logic [31:0] ctrl_q;
  logic sg_trip;
  always_comb begin
    sg_trip = 1'b0;
    for (int g = 0; g < 4; g++) begin
      if (ones({14'h0000, sg_f_q[4*g +: 4]}) >= 5'd2) begin
        sg_trip = 1'b1;
      end
    end
  end

  // turbine trip detect, open contact means tripped
  logic turb_trip;
  assign turb_trip = (ones({15'h0000, ~etf_n_s}) >= 5'd2) ||
                     (vlv_n_s == 4'h0);
  // p9 drops when three of four below
  logic p9;
  assign p9 = ones({14'h0000, ~p9_s}) < 5'd3;
  logic turb_rx_trip;
  assign turb_rx_trip = turb_trip && p9;

  logic [1:0] trouble;
  assign trouble = {|tr_q[17:9], |tr_q[8:0]};
  logic gw_trip;
  assign gw_trip = &trouble;

  assign o_p6  = |ir_s;
  logic p10_2oo4;
  logic p10_clear;
  assign p10_2oo4  = ones({14'h0000, p10_s}) >= 5'd2;
  assign p10_clear = ones({14'h0000, ~p10_s}) >= 5'd3;
  assign o_p10     = p10_2oo4;

  // source range block latch
  logic sr_blk_q;
  // manual reset between p6 and p10
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sr_blk_q <= 1'b0;
    end else if (!o_p6) begin
      sr_blk_q <= 1'b0;
    end else if (p10_2oo4) begin
      sr_blk_q <= 1'b1;
    end else if (|srrst_s) begin
      sr_blk_q <= 1'b0;
    end else if (|srblk_s) begin
      sr_blk_q <= 1'b1;
    end
  end
  assign o_sr_hv_on       = !sr_blk_q;
  assign o_sr_trip_active = !sr_blk_q;

  // ir and low pr blocks, one switch each per train
  logic [3:0] rng_blk_q;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rng_blk_q <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (p10_clear) begin
          rng_blk_q[k] <= 1'b0;
        end else if (p10_2oo4 && rblk_s[k]) begin
          rng_blk_q[k] <= 1'b1;
        end
      end
    end
  end
  assign o_ir_trip_active  = ~rng_blk_q[1:0];
  assign o_prl_trip_active = ~rng_blk_q[3:2];

  // loss of trip power demands trip
  logic auto_trip;
  assign auto_trip = sg_trip || turb_rx_trip || si_s || gw_trip ||
                     !pwr_ok_s || ctrl_q[0];

  // breaker coil drives, registered
  logic manual;
  assign manual = |man_s;
  // drop uv and fire shunt together
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_uv_coil      <= 2'b00;
      o_shunt_coil   <= 2'b11;
      o_reactor_trip <= 1'b1;
    end else begin
      o_uv_coil      <= {2{!(manual || auto_trip)}};
      o_shunt_coil   <= {2{manual || auto_trip}};
      o_reactor_trip <= manual || auto_trip;
    end
  end

  // alarm lamps, registered
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_train_alarm <= 2'b00;
    end else begin
      o_train_alarm <= trouble;
    end
  end

  // axi4-lite write side
  logic aw_h_q;
  logic w_h_q;
  logic [11:0] aw_a_q;
  logic [31:0] w_d_q;
  logic [3:0]  w_s_q;
  assign s_axi_awready = !aw_h_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_h_q && !s_axi_bvalid;
  logic [11:0] wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic        wgo;
  assign wa  = aw_h_q ? aw_a_q : s_axi_awaddr;
  assign wd  = w_h_q ? w_d_q : s_axi_wdata;
  assign ws  = w_h_q ? w_s_q : s_axi_wstrb;
  assign wgo = (aw_h_q || (s_axi_awvalid && s_axi_awready)) &&
               (w_h_q || (s_axi_wvalid && s_axi_wready));
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_h_q       <= 1'b0;
      w_h_q        <= 1'b0;
      aw_a_q       <= 12'h000;
      w_d_q        <= 32'h00000000;
      w_s_q        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TV_RESP_OKAY;
      ctrl_q       <= `TV_CTRL_RST;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wgo) begin
        aw_h_q       <= 1'b0;
        w_h_q        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wa[11:2] == `TV_OFS_CTRL >> 2) ?
                        `TV_RESP_OKAY : `TV_RESP_SLVERR;
        if (wa[11:2] == `TV_OFS_CTRL >> 2) begin
          for (int b = 0; b < 4; b++) begin
            if (ws[b]) begin
              ctrl_q[8*b +: 8] <= wd[8*b +: 8];
            end
          end
        end
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_h_q <= 1'b1;
          aw_a_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_h_q <= 1'b1;
          w_d_q <= s_axi_wdata;
          w_s_q <= s_axi_wstrb;
        end
      end
    end
  end

  // axi4-lite read side
  bus_state_t rd_q;
  assign s_axi_arready = (rd_q == BUS_IDLE);
  assign s_axi_rvalid  = (rd_q == BUS_RESP);
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_q        <= BUS_IDLE;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TV_RESP_OKAY;
    end else begin
      case (rd_q)
        BUS_IDLE: begin
          if (s_axi_arvalid) begin
            rd_q        <= BUS_RESP;
            s_axi_rresp <= `TV_RESP_OKAY;
            case (s_axi_araddr[11:2])
              `TV_OFS_CTRL >> 2:    s_axi_rdata <= ctrl_q;
              `TV_OFS_STATUS >> 2:  s_axi_rdata <= {19'h00000,
                rng_blk_q, sr_blk_q, o_p10, o_p6, p9, trouble,
                turb_trip, sg_trip, o_reactor_trip};
              `TV_OFS_INPUTS >> 2:  s_axi_rdata <= {16'h0000, sg_f_q};
              `TV_OFS_TROUBLE >> 2: s_axi_rdata <= {14'h0000, tr_q};
              default: begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `TV_RESP_SLVERR;
              end
            endcase
          end
        end
        BUS_RESP: begin
          if (s_axi_rready) begin
            rd_q <= BUS_IDLE;
          end
        end
        default: rd_q <= BUS_IDLE;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  AST_SI_TRIP: assert property (si_s |=> o_reactor_trip)
    else $error("si did not trip");
  AST_MAN_BOTH: assert property (manual |=> o_shunt_coil == 2'b11)
    else $error("manual did not fire both shunts");
  AST_MAN_UV: assert property (manual |=> o_uv_coil == 2'b00)
    else $error("manual did not drop uv");
  AST_MAN_NOBLK: assert property ((manual && rng_blk_q != 0)
    |=> o_reactor_trip) else $error("manual blocked");
  AST_GW_TRIP: assert property (gw_trip |=> o_reactor_trip)
    else $error("trouble coincidence no trip");
  AST_ALARM: assert property (trouble[0]
    |=> o_train_alarm[0]) else $error("alarm missing");
  AST_PWR: assert property (!pwr_ok_s |=> o_reactor_trip)
    else $error("power loss no trip");
  AST_SR_HELD: assert property (p10_2oo4 && o_p6 |=> sr_blk_q)
    else $error("sr block not held");
  AST_SR_CLR: assert property (!o_p6 |=> !sr_blk_q)
    else $error("sr block not cleared");
  AST_RNG_CLR: assert property (p10_clear |=> rng_blk_q == 4'h0)
    else $error("range blocks not cleared");
  AST_TURB: assert property (turb_trip && !p9 && !manual && !si_s &&
    !sg_trip && !gw_trip && pwr_ok_s && !ctrl_q[0]
    |=> !o_reactor_trip) else $error("turbine trip not blocked");
  AST_SG: assert property (sg_trip |=> o_reactor_trip)
    else $error("sg trip lost");
  COV_MAN: cover property (manual ##1 o_reactor_trip);
  COV_SRBLK: cover property (!sr_blk_q ##1 sr_blk_q);
  COV_RNG: cover property (rng_blk_q == 4'hf);
  COV_GW: cover property (gw_trip);
endmodule

// ==== hdl/trip_vote_consts.svh ====
// constants for the trip voting block
`ifndef TRIP_VOTE_CONSTS_SVH
`define TRIP_VOTE_CONSTS_SVH
`define TV_OFS_CTRL      12'h000
`define TV_OFS_STATUS    12'h004
`define TV_OFS_INPUTS    12'h008
`define TV_OFS_TROUBLE   12'h00c
`define TV_CTRL_RST      32'h00000000
`define TV_LAG_NS        50000
`define TV_LAG_CYC       ((`TV_LAG_NS + 4) / 5)
`define TV_LAG_W         14
`define TV_RESP_OKAY     2'b00
`define TV_RESP_SLVERR   2'b10
`endif

// ==== hdl/trip_vote_pkg.sv ====
// types for the trip voting block
package trip_vote_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_t;
endpackage

// ==== tb/field_side.sv ====
// far side model: turbine contacts, trip power and trip breakers
`timescale 1ns/1ps
module field_side (
  input  wire logic [2:0] i_etf_low,
  input  wire logic [3:0] i_vlv_shut,
  input  wire logic       i_pwr_lost,
  input  wire logic [1:0] i_uv_coil,
  input  wire logic [1:0] i_shunt_coil,
  output logic      [2:0] o_etf_contact_n,
  output logic      [3:0] o_stop_vlv_contact_n,
  output logic            o_trip_pwr_ok,
  output logic      [1:0] o_brk_open
);
  assign o_etf_contact_n      = ~i_etf_low;
  assign o_stop_vlv_contact_n = ~i_vlv_shut;
  // supply drops out when trip power is lost
  assign o_trip_pwr_ok        = ~i_pwr_lost;
  // breaker opens on coil dropout or shunt pick-up
  assign o_brk_open           = ~i_uv_coil | i_shunt_coil;
endmodule

// ==== tb/test_reactor_trip_voting_and_permissives.sv ====
// self-checking bench for the trip voting block
`timescale 1ns/1ps
`include "trip_vote_consts.svh"
module test_reactor_trip_voting_and_permissives;
  logic        i_sys_clk, i_arst_n, i_trip_pwr_ok, i_si_actuate, pwr_lost;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, o_reactor_trip, o_p6, o_p10;
  logic        o_sr_hv_on, o_sr_trip_active;
  logic [1:0]  s_axi_bresp, s_axi_rresp, i_man_trip, i_sr_block_sw;
  logic [1:0]  i_sr_reset_sw, i_ir_above, o_uv_coil, o_shunt_coil;
  logic [1:0]  o_train_alarm, o_ir_trip_active, o_prl_trip_active, brk;
  logic [2:0]  i_etf_contact_n, etf_low;
  logic [3:0]  i_stop_vlv_contact_n, vlv_shut, i_pr_above_p10;
  logic [3:0]  i_pr_above_p9, i_range_block_sw, s_axi_wstrb;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [15:0] i_sg_lowlow;
  logic [17:0] i_trouble;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          miscompares, num_checks;

  trip_vote trip_vote_i (.i_sys_clk, .i_arst_n, .i_sg_lowlow,
    .i_etf_contact_n, .i_stop_vlv_contact_n, .i_trip_pwr_ok, .i_si_actuate,
    .i_man_trip, .i_trouble, .i_ir_above, .i_pr_above_p10, .i_pr_above_p9,
    .i_sr_block_sw, .i_sr_reset_sw, .i_range_block_sw, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .o_uv_coil,
    .o_shunt_coil, .o_train_alarm, .o_reactor_trip, .o_p6, .o_p10,
    .o_sr_hv_on, .o_sr_trip_active, .o_ir_trip_active, .o_prl_trip_active);

  field_side field_side_i (.i_etf_low(etf_low), .i_vlv_shut(vlv_shut),
    .i_pwr_lost(pwr_lost), .i_uv_coil(o_uv_coil), .i_shunt_coil(o_shunt_coil),
    .o_etf_contact_n(i_etf_contact_n),
    .o_stop_vlv_contact_n(i_stop_vlv_contact_n),
    .o_trip_pwr_ok(i_trip_pwr_ok), .o_brk_open(brk));

  // 200 MHz clock
  always #2.5 i_sys_clk = ~i_sys_clk;

  // value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // trip flag, coils and breakers together
  task automatic chk_trip(input logic t, input string m);
    chk({25'h0, o_reactor_trip, o_uv_coil, o_shunt_coil, brk},
        t ? 32'h4f : 32'h30, m);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  // healthy plant, every bench input at zero
  task automatic normal;
    i_sg_lowlow      <= 16'h0000;
    etf_low          <= 3'h0;
    vlv_shut         <= 4'h0;
    pwr_lost         <= 1'b0;
    i_si_actuate     <= 1'b0;
    i_man_trip       <= 2'h0;
    i_trouble        <= 18'h00000;
    i_ir_above       <= 2'h0;
    i_pr_above_p10   <= 4'h0;
    i_pr_above_p9    <= 4'h0;
    i_sr_block_sw    <= 2'h0;
    i_sr_reset_sw    <= 2'h0;
    i_range_block_sw <= 4'h0;
  endtask

  // bus write, each channel released when taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic aw, w, b;
    int n;
    n = 0;
    @(posedge i_sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge i_sys_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w  = s_axi_wvalid && s_axi_wready;
      b  = s_axi_bvalid && s_axi_bready;
      if (b) chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
      @(posedge i_sys_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      n++;
    end while (!b && n < 50);
    if (!b) chk(32'h1, 32'h0, "no write answer");
  endtask

  // bus read
  task automatic axr(input logic [11:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    logic ar, r;
    int n;
    n = 0;
    @(posedge i_sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge i_sys_clk);
      ar = s_axi_arvalid && s_axi_arready;
      r  = s_axi_rvalid && s_axi_rready;
      if (r) chk(s_axi_rdata, ed, "rdata");
      if (r) chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
      @(posedge i_sys_clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
      n++;
    end while (!r && n < 50);
    if (!r) chk(32'h1, 32'h0, "no read answer");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog well past the expected run length
  initial begin
    #400000;
    chk(32'h1, 32'h0, "watchdog");
    give_verdict();
  end

  // main sequence
  initial begin
    i_sys_clk = 1'b0;
    i_arst_n = 1'b0;
    miscompares = 0;
    num_checks = 0;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    s_axi_awaddr <= 12'h000;
    s_axi_araddr <= 12'h000;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hf;
    normal();
    wt(4);
    chk_trip(1'b1, "in reset");
    @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    wt(10010);
    chk_trip(1'b0, "healthy");
    tend("reset");
    axr(`TV_OFS_CTRL, `TV_CTRL_RST, `TV_RESP_OKAY);
    axw(`TV_OFS_CTRL, 32'h1, `TV_RESP_OKAY);
    axr(`TV_OFS_CTRL, 32'h1, `TV_RESP_OKAY);
    wt(4);
    chk({31'h0, o_reactor_trip}, 32'h1, "forced trip");
    axw(`TV_OFS_STATUS, 32'h1, `TV_RESP_SLVERR);
    axw(12'h010, 32'h1, `TV_RESP_SLVERR);
    axr(12'h010, 32'h0, `TV_RESP_SLVERR);
    axr(`TV_OFS_INPUTS, 32'h0, `TV_RESP_OKAY);
    axw(`TV_OFS_CTRL, 32'h0, `TV_RESP_OKAY);
    wt(4);
    chk_trip(1'b0, "force off");
    tend("bus");
    // manual trips with every block and permissive raised
    @(posedge i_sys_clk);
    i_ir_above <= 2'h3;
    i_pr_above_p10 <= 4'hf;
    i_pr_above_p9 <= 4'hf;
    i_sr_block_sw <= 2'h3;
    i_range_block_sw <= 4'hf;
    for (int k = 0; k < 2; k++) begin
      @(posedge i_sys_clk);
      i_man_trip <= 2'h1 << k;
      wt(4);
      chk_trip(1'b1, "manual");
      @(posedge i_sys_clk);
      i_man_trip <= 2'h0;
      wt(4);
      chk_trip(1'b0, "manual off");
    end
    @(posedge i_sys_clk);
    normal();
    i_si_actuate <= 1'b1;
    wt(4);
    chk_trip(1'b1, "injection");
    @(posedge i_sys_clk);
    i_si_actuate <= 1'b0;
    pwr_lost <= 1'b1;
    wt(4);
    chk_trip(1'b1, "power lost");
    @(posedge i_sys_clk);
    pwr_lost <= 1'b0;
    i_pr_above_p9 <= 4'h3;
    tend("manual");
    // turbine trip votes, permissive on then off
    for (int i = 0; i < 8; i++) begin
      @(posedge i_sys_clk);
      etf_low <= i[2:0];
      wt(4);
      chk_trip($countones(i[2:0]) >= 2, "fluid vote");
    end
    @(posedge i_sys_clk);
    etf_low <= 3'h0;
    vlv_shut <= 4'h7;
    wt(4);
    chk_trip(1'b0, "three valves");
    @(posedge i_sys_clk);
    vlv_shut <= 4'hf;
    wt(4);
    chk_trip(1'b1, "all valves");
    @(posedge i_sys_clk);
    i_pr_above_p9 <= 4'h1;
    wt(4);
    chk_trip(1'b0, "below permissive");
    @(posedge i_sys_clk);
    normal();
    tend("turbine");
    // trouble annunciation per train
    for (int b = 0; b < 18; b++) begin
      @(posedge i_sys_clk);
      i_trouble <= 18'h1 << b;
      wt(4);
      chk({30'h0, o_train_alarm}, b < 9 ? 32'h1 : 32'h2,
          "alarm");
      chk_trip(1'b0, "one train");
    end
    @(posedge i_sys_clk);
    i_trouble <= 18'h00201;
    wt(4);
    chk_trip(1'b1, "both trains");
    axr(`TV_OFS_TROUBLE, 32'h201, `TV_RESP_OKAY);
    axr(`TV_OFS_STATUS, 32'h19, `TV_RESP_OKAY);
    axw(`TV_OFS_CTRL, 32'h2, `TV_RESP_OKAY);
    wt(4);
    chk({30'h0, o_train_alarm}, 32'h3, "alarm held");
    axw(`TV_OFS_CTRL, 32'h0, `TV_RESP_OKAY);
    @(posedge i_sys_clk);
    normal();
    tend("trouble");
    // source range block and reset
    @(posedge i_sys_clk);
    i_sr_block_sw <= 2'h2;
    wt(4);
    chk({29'h0, o_p6, o_sr_trip_active, o_sr_hv_on}, 32'h3, "no p6");
    @(posedge i_sys_clk);
    i_ir_above <= 2'h2;
    wt(4);
    chk({29'h0, o_p6, o_sr_trip_active, o_sr_hv_on}, 32'h4, "p6");
    @(posedge i_sys_clk);
    i_sr_block_sw <= 2'h0;
    i_sr_reset_sw <= 2'h1;
    wt(4);
    chk({30'h0, o_sr_trip_active, o_sr_hv_on}, 32'h3, "reset sw");
    @(posedge i_sys_clk);
    i_sr_reset_sw <= 2'h0;
    i_sr_block_sw <= 2'h1;
    wt(4);
    @(posedge i_sys_clk);
    i_sr_block_sw <= 2'h0;
    i_ir_above <= 2'h0;
    wt(4);
    chk({30'h0, o_sr_trip_active, o_sr_hv_on}, 32'h3, "p6 lost");
    @(posedge i_sys_clk);
    i_ir_above <= 2'h3;
    i_pr_above_p10 <= 4'h3;
    i_sr_reset_sw <= 2'h3;
    wt(4);
    chk({29'h0, o_p10, o_sr_trip_active, o_sr_hv_on}, 32'h4, "p10");
    tend("source");
    // range blocks per switch
    for (int j = 0; j < 4; j++) begin
      @(posedge i_sys_clk);
      i_pr_above_p10 <= 4'h1;
      i_range_block_sw <= 4'h1 << j;
      wt(4);
      chk({28'h0, o_prl_trip_active, o_ir_trip_active}, 32'hf,
          "no p10");
      @(posedge i_sys_clk);
      i_pr_above_p10 <= 4'h3;
      wt(4);
      chk({28'h0, o_prl_trip_active, o_ir_trip_active},
          {28'h0, ~(4'h1 << j)}, "one block");
      @(posedge i_sys_clk);
      i_range_block_sw <= 4'h0;
      i_pr_above_p10 <= 4'h1;
      wt(4);
      chk({28'h0, o_prl_trip_active, o_ir_trip_active}, 32'hf,
          "clear");
    end
    @(posedge i_sys_clk);
    normal();
    tend("range");
    // generator levels: split pair, then lagged pair
    @(posedge i_sys_clk);
    i_sg_lowlow <= 16'h1100;
    wt(10010);
    chk_trip(1'b0, "split pair");
    @(posedge i_sys_clk);
    i_sg_lowlow <= 16'h0900;
    wt(9000);
    chk_trip(1'b0, "lag");
    wt(1020);
    chk_trip(1'b1, "level pair");
    tend("level");
    give_verdict();
  end
endmodule
